// >>> core/striper_pkg.sv
package striper_pkg;

  localparam int unsigned NUM_CH       = 8;
  localparam int unsigned CH_IDX_W     = 3;
  localparam int unsigned LBA_W        = 48;
  localparam int unsigned UWORD_W      = 256;
  localparam int unsigned CWORD_W      = 32;
  localparam int unsigned ERR_W        = 8;
  localparam int unsigned DBG_W        = 32;
  localparam int unsigned IDENT_AW     = 7;
  localparam int unsigned USR_CNT_W    = 16;
  localparam int unsigned TMO_W        = 32;

  // one 512-byte sector is sixteen user words
  localparam int unsigned SECTOR_BYTES = 512;
  localparam int unsigned UWORD_BYTES  = UWORD_W / 8;
  localparam int unsigned SECTOR_WORDS = SECTOR_BYTES / UWORD_BYTES;
  localparam int unsigned BEAT_W       = 4;
  localparam int unsigned SUBS_PER_UW  = UWORD_W / CWORD_W;
  localparam int unsigned SUB_W        = 3;

  // user fifo count fields
  localparam int unsigned TX_CNT_LSB   = 4;
  localparam int unsigned RX_CNT_LSB   = 5;

  // channel buffers
  localparam int unsigned CH_BUF_BYTES = 16384;
  localparam int unsigned CH_BUF_DEPTH = CH_BUF_BYTES / UWORD_BYTES;
  localparam int unsigned CH_CNT_W     = $clog2(CH_BUF_DEPTH) + 1;

  // timeout handed to all channels
  localparam longint unsigned CLK_HZ         = 64'd100000000;
  localparam longint unsigned TIMEOUT_MS     = 64'd1000;
  localparam longint unsigned TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 64'd1000);

  localparam logic [LBA_W-1:0] CAP_RESET = 48'h0;

  typedef enum logic [1:0] {
    CMD_IDENTIFY = 2'h0,
    CMD_ERASE    = 2'h1,
    CMD_WRITE    = 2'h2,
    CMD_READ     = 2'h3
  } cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ISSUE = 3'h1,
    ST_ARM   = 3'h3,
    ST_CHECK = 3'h2,
    ST_MOVE  = 3'h6,
    ST_PAUSE = 3'h7,
    ST_DRAIN = 3'h5
  } stripe_state_t;

endpackage : striper_pkg

// >>> core/chan_buf_if.sv
`timescale 1ns/1ps
interface chan_buf_if #(
  parameter int unsigned CNT_W = striper_pkg::CH_CNT_W
);
  logic                             txPush;
  logic [striper_pkg::UWORD_W-1:0]  txWord;
  logic [CNT_W-1:0]                 txCount;
  logic                             rxPop;
  logic [striper_pkg::UWORD_W-1:0]  rxWord;
  logic [CNT_W-1:0]                 rxCount;

  modport striper (output txPush, output txWord, output rxPop,
                   input txCount, input rxWord, input rxCount);
  modport buffer  (input txPush, input txWord, input rxPop,
                   output txCount, output rxWord, output rxCount);
endinterface : chan_buf_if

// >>> core/channel_buffer_pair.sv
`timescale 1ns/1ps
module channel_buffer_pair #(
  parameter int unsigned DEPTH = striper_pkg::CH_BUF_DEPTH
) (
  input  wire logic                             ref_clk,
  input  wire logic                             rst,
  input  wire logic                             clkEn,
  chan_buf_if.buffer                            link,
  input  wire logic                             ctlTxRead,
  output logic [striper_pkg::CWORD_W-1:0]       ctlTxWord,
  output logic                                  ctlTxEmpty,
  input  wire logic                             ctlRxWrite,
  input  wire logic [striper_pkg::CWORD_W-1:0]  ctlRxWord,
  output logic                                  ctlRxFull
);
  localparam int unsigned AW    = $clog2(DEPTH);
  localparam int unsigned CNT_W = AW + 1;
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
  localparam logic [striper_pkg::SUB_W-1:0] LAST_SUB = striper_pkg::SUB_W'(striper_pkg::SUBS_PER_UW - 1);

  logic [striper_pkg::UWORD_W-1:0]  txMem [DEPTH];
  logic [striper_pkg::UWORD_W-1:0]  rxMem [DEPTH];
  logic [CNT_W-1:0]                 txWrPtr_r;
  logic [CNT_W-1:0]                 txRdPtr_r;
  logic [CNT_W-1:0]                 rxWrPtr_r;
  logic [CNT_W-1:0]                 rxRdPtr_r;
  logic [striper_pkg::SUB_W-1:0]    txSub_r;
  logic [striper_pkg::SUB_W-1:0]    rxSub_r;
  logic [striper_pkg::UWORD_W-striper_pkg::CWORD_W-1:0] rxAsm_r;
  logic                             txPop;
  logic                             rxPush;

  // narrowing side, low word first
  assign link.txCount = txWrPtr_r - txRdPtr_r;
  assign ctlTxEmpty   = (link.txCount == '0);
  assign txPop        = clkEn && ctlTxRead && !ctlTxEmpty && (txSub_r == LAST_SUB);

  always_ff @(posedge ref_clk) begin
    if (clkEn && link.txPush) begin
      txMem[txWrPtr_r[AW-1:0]] <= link.txWord; // R22
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      txWrPtr_r <= '0;
      txRdPtr_r <= '0;
      txSub_r   <= '0;
      ctlTxWord <= '0;
    end else if (clkEn) begin
      if (link.txPush) begin
        txWrPtr_r <= txWrPtr_r + 1'b1;
      end
      if (ctlTxRead && !ctlTxEmpty) begin
        ctlTxWord <= txMem[txRdPtr_r[AW-1:0]][{txSub_r, 5'h00} +: striper_pkg::CWORD_W];
        txSub_r   <= txSub_r + 1'b1;
      end
      if (txPop) begin
        txRdPtr_r <= txRdPtr_r + 1'b1;
      end
    end
  end

  // widening side
  assign link.rxCount = rxWrPtr_r - rxRdPtr_r;
  assign ctlRxFull    = (link.rxCount == FULL_CNT);
  assign link.rxWord  = rxMem[rxRdPtr_r[AW-1:0]];
  assign rxPush       = clkEn && ctlRxWrite && !ctlRxFull && (rxSub_r == LAST_SUB);

  always_ff @(posedge ref_clk) begin
    if (rxPush) begin
      rxMem[rxWrPtr_r[AW-1:0]] <= {ctlRxWord, rxAsm_r}; // R22
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rxWrPtr_r <= '0;
      rxRdPtr_r <= '0;
      rxSub_r   <= '0;
      rxAsm_r   <= '0;
    end else if (clkEn) begin
      if (ctlRxWrite && !ctlRxFull) begin
        rxSub_r <= rxSub_r + 1'b1;
        if (rxSub_r != LAST_SUB) begin
          rxAsm_r[{rxSub_r, 5'h00} +: striper_pkg::CWORD_W] <= ctlRxWord;
        end
      end
      if (rxPush) begin
        rxWrPtr_r <= rxWrPtr_r + 1'b1;
      end
      if (link.rxPop && (link.rxCount != '0)) begin
        rxRdPtr_r <= rxRdPtr_r + 1'b1;
      end
    end
  end

endmodule : channel_buffer_pair

// >>> core/eight_way_disk_striper.sv
`timescale 1ns/1ps
// Function
// R1 - active channel is current sector bits 2:0
// R2 - sector loads from start, steps per moved sector
// R3 - on accept, split start and length, request all channels
// R4 - codes: 00 identify, 01 erase, 10 write, 11 read
// R5 - requester gives 48-bit start and in-range count
// R6 - request only while idle, with valid fields
// R7 - no request taken while busy
// R8 - capacity is eight times channel 0, zero after reset
// R9 - error flag rises on nonzero error detail
// R10 - error flag clears only on reset
// R11 - error detail byte i copies channel i status
// R12 - receive writes need fill count bits 15:5 not all ones
// R13 - narrow receive counters pad upper bits with ones
// R14 - transmit reads need count bits 15:4 nonzero
// R15 - narrow transmit counters pad upper bits with zeros
// R16 - transmit word is valid a cycle after the strobe
// R17 - transmit empty flag ignored
// R18 - write needs one sector queued, two free in channel
// R19 - write strobe runs sixteen cycles per sector
// R20 - read needs one channel sector, two free user sectors
// R21 - receive strobe runs sixteen cycles per sector
// R22 - 16 kB narrowing and widening buffer per channel
// R23 - identify, debug and link-up pass through
// R24 - one shared 32-bit timeout in clock cycles
// R25 - clock and reset shared with controllers
// R26 - channel start is start/8 plus one below low bits, length its share
module eight_way_disk_striper #(
  parameter int unsigned     BUF_DEPTH      = striper_pkg::CH_BUF_DEPTH,
  parameter longint unsigned TIMEOUT_CYCLES = striper_pkg::TIMEOUT_CYCLES
) (
  input  wire logic                                                  ref_clk,
  input  wire logic                                                  rst,
  input  wire logic                                                  clkEn,
  // command
  input  wire logic [1:0]                                            command_code,
  input  wire logic [striper_pkg::LBA_W-1:0]                         start_sector,
  input  wire logic [striper_pkg::LBA_W-1:0]                         sector_count,
  input  wire logic                                                  command_request,
  output logic                                                       array_busy,
  output logic [striper_pkg::LBA_W-1:0]                              total_capacity,
  output logic                                                       array_error_flag,
  output logic [striper_pkg::NUM_CH*striper_pkg::ERR_W-1:0]          channel_error_detail,
  // user fifo
  input  wire logic [striper_pkg::USR_CNT_W-1:0]                     rx_fifo_fill_count,
  output logic                                                       rx_fifo_write_strobe,
  output logic [striper_pkg::UWORD_W-1:0]                            rx_fifo_write_word,
  input  wire logic [striper_pkg::USR_CNT_W-1:0]                     tx_fifo_data_count,
  input  wire logic                                                  tx_fifo_empty_flag,
  output logic                                                       tx_fifo_read_strobe,
  input  wire logic [striper_pkg::UWORD_W-1:0]                       tx_fifo_read_word,
  // status
  output logic [striper_pkg::NUM_CH-1:0][striper_pkg::DBG_W-1:0]     channel_debug_bus,
  output logic [striper_pkg::TMO_W-1:0]                              channel_timeout_value,
  output logic [striper_pkg::NUM_CH-1:0]                             channel_link_up,
  output logic [striper_pkg::NUM_CH-1:0][striper_pkg::IDENT_AW-1:0]  identify_write_addr,
  output logic [striper_pkg::NUM_CH-1:0]                             identify_write_strobe,
  output logic [striper_pkg::NUM_CH-1:0][striper_pkg::CWORD_W-1:0]   identify_write_word,
  // channels
  output logic [striper_pkg::NUM_CH-1:0]                             ctlCmdRequest,
  output logic [1:0]                                                 ctlCmdCode,
  output logic [striper_pkg::NUM_CH-1:0][striper_pkg::LBA_W-1:0]     ctlStartAddr,
  output logic [striper_pkg::NUM_CH-1:0][striper_pkg::LBA_W-1:0]     ctlLength,
  input  wire logic [striper_pkg::NUM_CH-1:0]                        ctlBusy,
  input  wire logic [striper_pkg::LBA_W-1:0]                         ctlCapacity0,
  input  wire logic [striper_pkg::NUM_CH-1:0][striper_pkg::ERR_W-1:0] ctlErrorStatus,
  input  wire logic [striper_pkg::NUM_CH-1:0][striper_pkg::DBG_W-1:0] ctlDebugIn,
  input  wire logic [striper_pkg::NUM_CH-1:0]                        ctlLinkUp,
  input  wire logic [striper_pkg::NUM_CH-1:0][striper_pkg::IDENT_AW-1:0] ctlIdentAddr,
  input  wire logic [striper_pkg::NUM_CH-1:0]                        ctlIdentStrobe,
  input  wire logic [striper_pkg::NUM_CH-1:0][striper_pkg::CWORD_W-1:0] ctlIdentWord,
  input  wire logic [striper_pkg::NUM_CH-1:0]                        ctlTxRead,
  output logic [striper_pkg::NUM_CH-1:0][striper_pkg::CWORD_W-1:0]   ctlTxWord,
  output logic [striper_pkg::NUM_CH-1:0]                             ctlTxEmpty,
  input  wire logic [striper_pkg::NUM_CH-1:0]                        ctlRxWrite,
  input  wire logic [striper_pkg::NUM_CH-1:0][striper_pkg::CWORD_W-1:0] ctlRxWord,
  output logic [striper_pkg::NUM_CH-1:0]                             ctlRxFull
);

  localparam int unsigned CNT_W = $clog2(BUF_DEPTH) + 1;
  localparam logic [CNT_W-1:0] ONE_SECTOR  = CNT_W'(striper_pkg::SECTOR_WORDS);
  localparam logic [CNT_W:0]   TWO_SECTORS = (CNT_W+1)'(2 * striper_pkg::SECTOR_WORDS);
  localparam logic [CNT_W:0]   DEPTH_WIDE  = (CNT_W+1)'(BUF_DEPTH);
  localparam logic [striper_pkg::BEAT_W-1:0] LAST_BEAT = striper_pkg::BEAT_W'(striper_pkg::SECTOR_WORDS - 1);
  localparam logic [striper_pkg::TMO_W-1:0]  TIMEOUT_VAL = striper_pkg::TMO_W'(TIMEOUT_CYCLES);

  // channel start: start/8, plus one below the low bits
  function automatic logic [striper_pkg::LBA_W-1:0] chanAddr(
    input logic [striper_pkg::LBA_W-1:0]    start,
    input logic [striper_pkg::CH_IDX_W-1:0] ch
  );
    logic [striper_pkg::LBA_W-1:0] base;
    base     = {3'h0, start[striper_pkg::LBA_W-1:striper_pkg::CH_IDX_W]};
    chanAddr = base + ((ch < start[striper_pkg::CH_IDX_W-1:0]) ? 48'h1 : 48'h0);
  endfunction : chanAddr

  // share: ceil((n - d) / 8), d from first channel
  function automatic logic [striper_pkg::LBA_W-1:0] chanLen(
    input logic [striper_pkg::LBA_W-1:0]    n,
    input logic [striper_pkg::CH_IDX_W-1:0] low,
    input logic [striper_pkg::CH_IDX_W-1:0] ch
  );
    logic [striper_pkg::CH_IDX_W-1:0] d;
    logic [striper_pkg::LBA_W:0]      s;
    d       = ch - low;
    s       = {1'b0, n} + 49'h7 - {46'h0, d};
    chanLen = {2'h0, s[striper_pkg::LBA_W:striper_pkg::CH_IDX_W]};
  endfunction : chanLen

  striper_pkg::stripe_state_t        state_r;
  striper_pkg::cmd_t                 cmd_r;
  logic [striper_pkg::LBA_W-1:0]     curSector_r;
  logic [striper_pkg::LBA_W-1:0]     remain_r;
  logic [striper_pkg::BEAT_W-1:0]    beat_r;
  logic                              txPushDly_r;
  logic [striper_pkg::CH_IDX_W-1:0]  txChDly_r;
  logic [striper_pkg::CH_IDX_W-1:0]  activeCh;

  logic                              isWrite;
  logic                              isRead;
  logic                              sectorReady;
  logic                              moveDone;
  logic                              rxPopNow;

  logic [striper_pkg::NUM_CH-1:0][CNT_W-1:0]               txCountArr;
  logic [striper_pkg::NUM_CH-1:0][CNT_W-1:0]               rxCountArr;
  logic [striper_pkg::NUM_CH-1:0][striper_pkg::UWORD_W-1:0] rxWordArr;
  logic [CNT_W:0]                    txFree;

  assign activeCh = curSector_r[striper_pkg::CH_IDX_W-1:0]; // R1
  assign isWrite  = (cmd_r == striper_pkg::CMD_WRITE); // R4
  assign isRead   = (cmd_r == striper_pkg::CMD_READ); // R4
  // free words in active channel
  assign txFree   = DEPTH_WIDE - {1'b0, txCountArr[activeCh]};

  // counts only; empty flag unread
  always_comb begin
    sectorReady = 1'b0;
    if (isWrite) begin
      sectorReady = (tx_fifo_data_count[striper_pkg::USR_CNT_W-1:striper_pkg::TX_CNT_LSB] != '0) // R14 R17
                    && (txFree >= TWO_SECTORS); // R18
    end else if (isRead) begin
      sectorReady = (rxCountArr[activeCh] >= ONE_SECTOR) // R20
                    && !(&rx_fifo_fill_count[striper_pkg::USR_CNT_W-1:striper_pkg::RX_CNT_LSB]); // R12
    end
  end

  assign moveDone            = (state_r == striper_pkg::ST_MOVE) && (beat_r == LAST_BEAT);
  assign array_busy          = (state_r != striper_pkg::ST_IDLE); // R7

  assign tx_fifo_read_strobe = clkEn && (state_r == striper_pkg::ST_MOVE) && isWrite; // R19
  assign rxPopNow            = clkEn && (state_r == striper_pkg::ST_MOVE) && isRead; // R21

  // command sequencing
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= striper_pkg::ST_IDLE;
    end else if (clkEn) begin
      unique case (state_r)
        striper_pkg::ST_IDLE: begin
          if (command_request) begin
            state_r <= striper_pkg::ST_ISSUE; // R7
          end
        end

        striper_pkg::ST_ISSUE: begin
          state_r <= striper_pkg::ST_ARM;
        end

        striper_pkg::ST_ARM: begin
          if ((isWrite || isRead) && (remain_r != '0)) begin
            state_r <= striper_pkg::ST_CHECK;
          end else begin
            state_r <= striper_pkg::ST_DRAIN;
          end
        end

        striper_pkg::ST_CHECK: begin
          if (sectorReady) begin
            state_r <= striper_pkg::ST_MOVE;
          end
        end

        striper_pkg::ST_MOVE: begin
          if (beat_r == LAST_BEAT) begin
            state_r <= (remain_r == 48'h1) ? striper_pkg::ST_DRAIN : striper_pkg::ST_PAUSE;
          end
        end

        striper_pkg::ST_PAUSE: begin
          state_r <= striper_pkg::ST_CHECK;
        end

        striper_pkg::ST_DRAIN: begin
          if ((ctlBusy == '0) && !txPushDly_r && !rx_fifo_write_strobe) begin
            state_r <= striper_pkg::ST_IDLE;
          end
        end

        default: begin
          state_r <= striper_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // capture and split
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmd_r        <= striper_pkg::CMD_IDENTIFY;
      ctlCmdCode   <= 2'h0;
      ctlStartAddr <= '0;
      ctlLength    <= '0;
    end else if (clkEn && (state_r == striper_pkg::ST_IDLE) && command_request) begin
      cmd_r      <= striper_pkg::cmd_t'(command_code);
      ctlCmdCode <= command_code;
      for (int i = 0; i < striper_pkg::NUM_CH; i++) begin
        ctlStartAddr[i] <= chanAddr(start_sector, striper_pkg::CH_IDX_W'(i)); // R3 R26
        ctlLength[i]    <= chanLen(sector_count, start_sector[striper_pkg::CH_IDX_W-1:0],
                                   striper_pkg::CH_IDX_W'(i)); // R3 R26
      end
    end
  end

  // one-cycle request to every channel
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctlCmdRequest <= '0;
    end else if (clkEn) begin
      ctlCmdRequest <= (state_r == striper_pkg::ST_ISSUE) ? '1 : '0; // R3
    end
  end

  // sector, remaining, beat
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      curSector_r <= '0;
      remain_r    <= '0;
      beat_r      <= '0;
    end else if (clkEn) begin
      if ((state_r == striper_pkg::ST_IDLE) && command_request) begin
        curSector_r <= start_sector; // R2
        remain_r    <= sector_count;
      end else if (moveDone) begin
        curSector_r <= curSector_r + 48'h1; // R2
        remain_r    <= remain_r - 48'h1;
      end

      if (state_r == striper_pkg::ST_MOVE) begin
        beat_r <= beat_r + 1'b1; // R19 R21
      end else begin
        beat_r <= '0;
      end
    end
  end

  // user word comes a cycle after strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      txPushDly_r <= 1'b0;
      txChDly_r   <= '0;
    end else if (clkEn) begin
      txPushDly_r <= tx_fifo_read_strobe; // R16
      txChDly_r   <= activeCh;
    end
  end

  // read path, registered
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_fifo_write_strobe <= 1'b0;
      rx_fifo_write_word   <= '0;
    end else if (clkEn) begin
      rx_fifo_write_strobe <= rxPopNow; // R21
      if (rxPopNow) begin
        rx_fifo_write_word <= rxWordArr[activeCh];
      end
    end
  end

  // capacity, error status
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      total_capacity       <= striper_pkg::CAP_RESET; // R8
      channel_error_detail <= '0;
      array_error_flag     <= 1'b0;
    end else if (clkEn) begin

      total_capacity       <= {ctlCapacity0[striper_pkg::LBA_W-4:0], 3'h0}; // R8
      channel_error_detail <= ctlErrorStatus; // R11
      if (channel_error_detail != '0) begin
        array_error_flag <= 1'b1; // R9 R10
      end
    end
  end

  // per-channel pass-through, shared timeout
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      channel_debug_bus     <= '0;
      channel_link_up       <= '0;
      identify_write_addr   <= '0;
      identify_write_strobe <= '0;
      identify_write_word   <= '0;
      channel_timeout_value <= TIMEOUT_VAL; // R24
    end else if (clkEn) begin

      channel_debug_bus     <= ctlDebugIn; // R23
      channel_link_up       <= ctlLinkUp; // R23
      identify_write_addr   <= ctlIdentAddr; // R23
      identify_write_strobe <= ctlIdentStrobe; // R23
      identify_write_word   <= ctlIdentWord; // R23
      channel_timeout_value <= TIMEOUT_VAL; // R24
    end
  end

  // eight channel buffer pairs
  for (genvar g = 0; g < striper_pkg::NUM_CH; g++) begin : g_ch
    chan_buf_if #(.CNT_W(CNT_W)) bufIf ();


    assign bufIf.txPush  = clkEn && txPushDly_r && (txChDly_r == striper_pkg::CH_IDX_W'(g)); // R19
    assign bufIf.txWord  = tx_fifo_read_word; // R16
    assign bufIf.rxPop   = rxPopNow && (activeCh == striper_pkg::CH_IDX_W'(g)); // R1
    assign txCountArr[g] = bufIf.txCount;
    assign rxCountArr[g] = bufIf.rxCount;
    assign rxWordArr[g]  = bufIf.rxWord;

    channel_buffer_pair #(.DEPTH(BUF_DEPTH)) u_buf (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .clkEn      (clkEn),
      .link       (bufIf),
      .ctlTxRead  (ctlTxRead[g]),
      .ctlTxWord  (ctlTxWord[g]),
      .ctlTxEmpty (ctlTxEmpty[g]),
      .ctlRxWrite (ctlRxWrite[g]),
      .ctlRxWord  (ctlRxWord[g]),
      .ctlRxFull  (ctlRxFull[g])
    ); // R22
  end

endmodule : eight_way_disk_striper

// >>> bench/striper_sva.sv
`timescale 1ns/1ps
module striper_sva (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        clkEn,
  input wire logic        command_request,
  input wire logic        array_busy,
  input wire logic        array_error_flag,
  input wire logic [63:0] channel_error_detail,
  input wire logic        tx_fifo_read_strobe,
  input wire logic [15:0] tx_fifo_data_count,
  input wire logic        rx_fifo_write_strobe,
  input wire logic [15:0] rx_fifo_fill_count,
  input wire logic [7:0]  ctlCmdRequest
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [4:0] txRun_r, rxRun_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      txRun_r <= 5'h0;
      rxRun_r <= 5'h0;
    end else begin
      txRun_r <= tx_fifo_read_strobe ? txRun_r + 5'h1 : 5'h0;
      rxRun_r <= rx_fifo_write_strobe ? rxRun_r + 5'h1 : 5'h0;
    end
  end
  take_req_a: assert property (command_request && clkEn && !array_busy |=> array_busy)
    else $error("no accept");
  fan_out_a: assert property ($rose(array_busy) |=> ctlCmdRequest == 8'hff)
    else $error("no fan-out");
  err_set_a: assert property (channel_error_detail != 64'h0 |=> array_error_flag)
    else $error("flag not set");
  err_hold_a: assert property (array_error_flag |=> array_error_flag)
    else $error("flag cleared");
  tx_gate_a: assert property ($rose(tx_fifo_read_strobe) |-> $past(tx_fifo_data_count[15:4]) != 12'h0)
    else $error("early read");
  tx_run_a: assert property ($fell(tx_fifo_read_strobe) |-> txRun_r == 5'h10)
    else $error("read run");
  rx_gate_a: assert property ($rose(rx_fifo_write_strobe) |-> $past(rx_fifo_fill_count[15:5], 2) != 11'h7ff)
    else $error("write when full");
  rx_run_a: assert property ($fell(rx_fifo_write_strobe) |-> rxRun_r == 5'h10)
    else $error("write run");
  cover property ($fell(tx_fifo_read_strobe));
  cover property ($fell(rx_fifo_write_strobe));
  cover property ($rose(array_error_flag));
endmodule : striper_sva
bind eight_way_disk_striper striper_sva chk (.*);

// >>> bench/chan_model.sv
`timescale 1ns/1ps
module chan_model (
  input  logic             ref_clk,
  input  logic             rst,
  input  logic [7:0]       ctlCmdRequest,
  input  logic [1:0]       ctlCmdCode,
  input  logic [7:0][47:0] ctlLength,
  input  logic [7:0]       ctlTxEmpty,
  input  logic [7:0]       ctlRxFull,
  output logic [7:0]       ctlBusy,
  output logic [7:0]       ctlTxRead,
  output logic [7:0]       ctlRxWrite,
  output logic [7:0][31:0] ctlRxWord
);
  logic [23:0] left_r [8];
  logic [1:0]  hold_r [8];
  for (genvar i = 0; i < 8; i++) begin : g_ch
    assign ctlBusy[i]    = left_r[i] != 24'h0 || hold_r[i] != 2'h0;
    assign ctlTxRead[i]  = ctlCmdCode == 2'h2 && left_r[i] != 24'h0 && !ctlTxEmpty[i];
    assign ctlRxWrite[i] = ctlCmdCode == 2'h3 && left_r[i] != 24'h0 && !ctlRxFull[i];
    assign ctlRxWord[i]  = ctlRxWrite[i] ? {8'(i), left_r[i]} : ~{8'(i), left_r[i]};
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        left_r[i] <= 24'h0;
        hold_r[i] <= 2'h0;
      end else if (ctlCmdRequest[i]) begin
        hold_r[i] <= 2'h3;
        left_r[i] <= ctlCmdCode[1] ? {ctlLength[i][16:0], 7'h0} : 24'h0;
      end else begin
        hold_r[i] <= hold_r[i] - 2'(hold_r[i] != 2'h0);
        left_r[i] <= left_r[i] - 24'(ctlTxRead[i] || ctlRxWrite[i]);
      end
    end
  end
endmodule : chan_model

// >>> bench/eight_way_disk_striper_test.sv
`timescale 1ns/1ps
module eight_way_disk_striper_test;
  logic ref_clk, rst, clkEn, command_request, array_busy, array_error_flag, tx_fifo_empty_flag;
  logic rx_fifo_write_strobe, tx_fifo_read_strobe;
  logic [1:0] command_code, ctlCmdCode;
  logic [15:0] rx_fifo_fill_count, tx_fifo_data_count, rxFill, txAvail;
  logic [31:0] channel_timeout_value, firstRx;
  logic [47:0] start_sector, sector_count, total_capacity, ctlCapacity0;
  logic [63:0] channel_error_detail;
  logic [255:0] rx_fifo_write_word, tx_fifo_read_word;
  logic [7:0] channel_link_up, identify_write_strobe, ctlCmdRequest, ctlBusy, ctlLinkUp, ctlIdentStrobe;
  logic [7:0] ctlTxRead, ctlTxEmpty, ctlRxWrite, ctlRxFull;
  logic [7:0][6:0] identify_write_addr, ctlIdentAddr;
  logic [7:0][7:0] ctlErrorStatus;
  logic [7:0][31:0] channel_debug_bus, identify_write_word, ctlDebugIn, ctlIdentWord, ctlTxWord, ctlRxWord;
  logic [7:0][47:0] ctlStartAddr, ctlLength;
  int nMismatch, checked, nTx, nRx, cyc;
  assign tx_fifo_data_count = txAvail - 16'(nTx);
  assign rx_fifo_fill_count = rxFill;
  eight_way_disk_striper #(.BUF_DEPTH(64), .TIMEOUT_CYCLES(1000)) DUT (.*);
  chan_model CH (.*);
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic end_sim();
    if (nMismatch == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
    checked++;
    if (seen !== exp) begin
      nMismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      nMismatch++;
      end_sim();
    end
    if (tx_fifo_read_strobe === 1'b1) begin
      nTx <= nTx + 1;
      tx_fifo_read_word <= {8{32'(nTx)}};
    end
    if (rx_fifo_write_strobe === 1'b1) begin
      if (nRx == 0) firstRx <= rx_fifo_write_word[31:0];
      nRx <= nRx + 1;
    end
  end
  task automatic cmd(input logic [1:0] c, input logic [47:0] s, input logic [47:0] n);
    @(posedge ref_clk);
    command_code <= c;
    start_sector <= s;
    sector_count <= n;
    command_request <= 1'b1;
    @(posedge ref_clk);
    command_request <= 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(ctlCmdCode, c);
    for (int i = 0; i < 8; i++) begin
      chk(ctlStartAddr[i], (s >> 3) + 48'(i < s[2:0]));
      chk(ctlLength[i], (n + 48'd7 - 48'((i - s[2:0]) & 7)) >> 3);
    end
  endtask : cmd
  task automatic idle();
    @(negedge ref_clk);
    while (array_busy !== 1'b0) @(negedge ref_clk);
  endtask : idle
  initial begin
    rst = 1'b1;
    clkEn = 1'b1;
    command_request = 1'b0;
    command_code = 2'h0;
    start_sector = 48'h0;
    sector_count = 48'h0;
    tx_fifo_empty_flag = 1'b1;
    txAvail = 16'h0020;
    rxFill = 16'hffe0;
    ctlCapacity0 = 48'h1234_5678;
    ctlErrorStatus = 64'h0;
    ctlDebugIn = {8{32'hc0de_0001}};
    ctlLinkUp = 8'h5a;
    ctlIdentAddr = {8{7'h2b}};
    ctlIdentStrobe = 8'h96;
    ctlIdentWord = {8{32'h0bad_f00d}};
    repeat (20) @(posedge ref_clk);
    chk(total_capacity, 48'h0);
    rst <= 1'b0;
    repeat (3) @(negedge ref_clk);
    chk(total_capacity, 48'h91a2_b3c0);
    chk(channel_timeout_value, 32'h3e8);
    chk(channel_debug_bus, ctlDebugIn);
    chk(identify_write_word, ctlIdentWord);
    chk({identify_write_addr, identify_write_strobe, channel_link_up}, {ctlIdentAddr, ctlIdentStrobe, ctlLinkUp});
    for (int c = 0; c < 2; c++) begin
      cmd(2'(c), 48'h9, 48'h1);
      idle();
    end
    cmd(2'h2, 48'h6, 48'h3);
    repeat (300) @(posedge ref_clk);
    command_code <= 2'h0;
    command_request <= 1'b1;
    @(posedge ref_clk);
    command_request <= 1'b0;
    @(negedge ref_clk);
    chk(ctlCmdCode, 2'h2);
    chk(nTx, 32);
    chk(array_busy, 1'b1);
    @(posedge ref_clk);
    txAvail <= 16'h0030;
    idle();
    chk(nTx, 48);
    cmd(2'h3, 48'hd, 48'h2);
    repeat (200) @(negedge ref_clk);
    chk(nRx, 0);
    @(posedge ref_clk);
    rxFill <= 16'h0000;
    idle();
    chk(nRx, 32);
    chk(firstRx, 32'h0500_0080);
    @(posedge ref_clk);
    ctlErrorStatus[3] <= 8'h40;
    repeat (3) @(negedge ref_clk);
    chk(channel_error_detail, 64'h4000_0000);
    chk(array_error_flag, 1'b1);
    @(posedge ref_clk);
    ctlErrorStatus[3] <= 8'h00;
    repeat (3) @(negedge ref_clk);
    chk(array_error_flag, 1'b1);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(negedge ref_clk);
    chk(array_error_flag, 1'b0);
    end_sim();
  end
endmodule : eight_way_disk_striper_test
